// File: pba_pkg.sv
`default_nettype none
// Contract
// - sample bus on rising 33MHz clock
// - reset puts bus outputs benign, tri-stated
// - grant lines tri-stated during reset
// - reset parking drives only logic low
// - reset asserts and releases asynchronously
// - one address phase, then data phases
// - frame's first clock carries 32-bit address
// - low lane least, high lane most significant
// - data moves when both readies asserted
// - command, then stable per-lane byte enables
// - even parity over address/data and enables
// - parity lags one clock, holds one after
// - master drives write parity, target read
// - target ready means data valid/acceptable
// - target asks stop through stop line
// - locked target excludes aligned 16 bytes
// - grant alone gives no lock ownership
// - init select is configuration chip select
// - target claims access by driving devsel
// - data parity error flagged two clocks later
// - system error driven exactly one clock
// - arbiter ignores requests during reset
package pba_pkg;
   localparam int PCI_CLK_MHZ = 33;
   localparam int SLOTS = 2;
   localparam int LOCK_LSB = 4;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'ha;
   localparam logic [3:0] CMD_CFG_WR = 4'hb;
   localparam logic [3:0] CMD_MEM_RDM = 4'hc;
   localparam logic [3:0] CMD_MEM_RDL = 4'he;
   localparam logic [3:0] CMD_MEM_WRI = 4'hf;

   typedef enum logic [2:0] {
      PBA_IDLE = 3'h0,
      PBA_DATA = 3'h1,
      PBA_STOP = 3'h2,
      PBA_TURN = 3'h3,
      PBA_BUSY = 3'h4
   } pba_state_t;

   typedef struct packed {
      logic [29:0] addr;
      logic [31:0] data;
      logic [3:0] be;
   } pba_wr_t;

   typedef struct packed {
      pba_state_t state;
      logic frmQ;
      logic irdyQ;
      logic [29:0] addr;
      logic rd;
      logic cfg;
      logic locked;
      logic lockCand;
      logic [27:0] lockArea;
      logic [31:0] adOut;
      logic adOe;
      logic cbeOe;
      logic parOut;
      logic parOe;
      logic devsel_n;
      logic trdy_n;
      logic stop_n;
      logic ctlOe;
      logic aParChk;
      logic aParCalc;
      logic dParChk;
      logic dParCalc;
      logic perr_n;
      logic perrOe;
      logic serrOe;
      logic [SLOTS-1:0] gnt_n;
      logic gntOe;
      logic rr;
      pba_wr_t wr;
      logic wrTgl;
      logic enS1;
      logic enS2;
   } pba_pci_t;

   // bus parked low during reset, every other driver released
   localparam pba_pci_t PCI_RST = '{state: PBA_IDLE, frmQ: 1'b1, irdyQ: 1'b1, adOe: 1'b1, cbeOe: 1'b1,
      parOe: 1'b1, devsel_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1, perr_n: 1'b1, gnt_n: '1, default: '0};

   typedef struct packed {
      logic tS1;
      logic tS2;
      logic tS3;
      pba_wr_t wr;
      logic wrStb;
      logic en;
   } pba_sys_t;
endpackage
`default_nettype wire

// File: pba_agent.sv
`timescale 1ns/1ps
`default_nettype none
module pba_agent #(
   parameter int DEPTH_LOG2 = 6,
   parameter logic [31:0] BASE_ADDR = 32'h8000_0000,
   parameter logic [31:0] CFG_ID = 32'h0001_0001 // arbitrary identity value
)(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic tgtEnable,
   output logic [29:0] wrAddr,
   output logic [31:0] wrData,
   output logic [3:0] wrBe,
   output logic wrStrobe,
   input wire logic pciClk,
   input wire logic pciRst_n,
   input wire logic frameIn_n,
   input wire logic irdyIn_n,
   input wire logic [31:0] adIn,
   input wire logic [3:0] cbeIn_n,
   input wire logic parIn,
   input wire logic idsel,
   input wire logic lockIn_n,
   input wire logic [pba_pkg::SLOTS-1:0] reqIn_n,
   output logic [31:0] adOut,
   output logic adOe,
   output logic [3:0] cbeOut_n,
   output logic cbeOe,
   output logic parOut,
   output logic parOe,
   output logic devselOut_n,
   output logic trdyOut_n,
   output logic stopOut_n,
   output logic ctlOe,
   output logic perrOut_n,
   output logic perrOe,
   output logic serrOut_n,
   output logic serrOe,
   output logic [pba_pkg::SLOTS-1:0] gntOut_n,
   output logic gntOe
);
   // ***************************************************
   // bus side, on the slot clock
   // ***************************************************
   pba_pkg::pba_pci_t p_q;
   pba_pkg::pba_pci_t p_d;
   pba_pkg::pba_sys_t s_q;
   pba_pkg::pba_sys_t s_d;
   logic [31:0] mem [2**DEPTH_LOG2];
   logic [3:0] cmd;
   logic [DEPTH_LOG2-1:0] idx;
   logic addrPh;
   logic xfer;
   logic memCmd;
   logic cfgCmd;
   logic hit;
   logic lockHit;
   logic lastWord;
   logic wrMem;
   logic canClaim;
   logic parNow;

   function automatic logic [31:0] wordAt(input logic [29:0] a, input logic isCfg);
      if (isCfg)
      begin
         wordAt = (a[5:0] == 6'h0) ? CFG_ID : 32'h0;
      end
      else
      begin
         wordAt = mem[a[DEPTH_LOG2-1:0]];
      end
   endfunction

   assign cmd = cbeIn_n;
   assign addrPh = !frameIn_n && p_q.frmQ && p_q.irdyQ;
   assign xfer = !irdyIn_n && !p_q.trdy_n && p_q.state == pba_pkg::PBA_DATA;
   assign memCmd = cmd == pba_pkg::CMD_MEM_RD || cmd == pba_pkg::CMD_MEM_WR || cmd == pba_pkg::CMD_MEM_RDM
      || cmd == pba_pkg::CMD_MEM_RDL || cmd == pba_pkg::CMD_MEM_WRI;
   assign cfgCmd = cmd == pba_pkg::CMD_CFG_RD || cmd == pba_pkg::CMD_CFG_WR;
   // memory answers only once enabled from the system side; configuration always
   assign hit = (memCmd && p_q.enS2 && adIn[31:DEPTH_LOG2+2] == BASE_ADDR[31:DEPTH_LOG2+2])
      || (cfgCmd && idsel && adIn[1:0] == 2'h0);
   assign lockHit = p_q.locked && !lockIn_n && adIn[31:pba_pkg::LOCK_LSB] == p_q.lockArea;
   assign idx = p_q.addr[DEPTH_LOG2-1:0];
   assign lastWord = &idx;
   assign wrMem = xfer && !p_q.rd && !p_q.cfg;
   assign canClaim = p_q.state == pba_pkg::PBA_IDLE || p_q.state == pba_pkg::PBA_TURN;
   assign parNow = ^{p_q.adOut, cbeIn_n};

   always_comb
   begin
      p_d = p_q;
      p_d.frmQ = frameIn_n;
      p_d.irdyQ = irdyIn_n;
      p_d.cbeOe = 1'b0;
      p_d.enS1 = s_q.en;
      p_d.enS2 = p_q.enS1;
      // only read data is ours to cover with parity
      p_d.parOe = p_q.adOe && p_q.state != pba_pkg::PBA_IDLE;
      p_d.parOut = parNow;
      p_d.aParChk = addrPh;
      p_d.aParCalc = ^{adIn, cbeIn_n};
      p_d.serrOe = p_q.aParChk && (parIn != p_q.aParCalc);
      p_d.dParChk = xfer && !p_q.rd;
      p_d.dParCalc = ^{adIn, cbeIn_n};
      if (p_q.dParChk && parIn != p_q.dParCalc)
      begin
         p_d.perr_n = 1'b0;
         p_d.perrOe = 1'b1;
      end
      else if (!p_q.perr_n)
      begin
         p_d.perr_n = 1'b1;
         p_d.perrOe = 1'b1;
      end
      else
      begin
         p_d.perrOe = 1'b0;
      end
      if (frameIn_n && lockIn_n)
      begin
         p_d.locked = 1'b0;
      end
      unique case (p_q.state)
         pba_pkg::PBA_IDLE:
         begin
            p_d.adOe = 1'b0;
         end
         pba_pkg::PBA_BUSY:
         begin
            if (frameIn_n && irdyIn_n)
            begin
               p_d.state = pba_pkg::PBA_IDLE;
            end
         end
         pba_pkg::PBA_DATA:
         begin
            // ownership comes from the lock handshake, never from the grant
            if (p_q.lockCand)
            begin
               p_d.lockCand = 1'b0;
               if (!lockIn_n)
               begin
                  p_d.locked = 1'b1;
                  p_d.lockArea = p_q.addr[29:2];
               end
            end
            if (p_q.rd && p_q.trdy_n)
            begin
               p_d.adOe = 1'b1;
               p_d.adOut = wordAt(p_q.addr, p_q.cfg);
               p_d.trdy_n = 1'b0;
            end
            else if (xfer)
            begin
               p_d.addr = p_q.addr + 30'h1;
               p_d.adOut = wordAt(p_q.addr + 30'h1, p_q.cfg);
               if (frameIn_n)
               begin
                  p_d.state = pba_pkg::PBA_TURN;
                  p_d.adOe = 1'b0;
                  p_d.devsel_n = 1'b1;
                  p_d.trdy_n = 1'b1;
               end
               else if (lastWord)
               begin
                  // no wrap: disconnect at the end of the window
                  p_d.state = pba_pkg::PBA_STOP;
                  p_d.adOe = 1'b0;
                  p_d.trdy_n = 1'b1;
                  p_d.stop_n = 1'b0;
               end
            end
         end
         pba_pkg::PBA_STOP:
         begin
            if (frameIn_n)
            begin
               p_d.state = pba_pkg::PBA_TURN;
               p_d.stop_n = 1'b1;
               p_d.devsel_n = 1'b1;
            end
         end
         pba_pkg::PBA_TURN:
         begin
            // controls were driven high for one clock, now released
            p_d.ctlOe = 1'b0;
            p_d.state = pba_pkg::PBA_IDLE;
         end
         default:
         begin
            p_d.state = pba_pkg::PBA_IDLE;
         end
      endcase
      if (canClaim && addrPh)
      begin
         p_d.cfg = cfgCmd;
         p_d.rd = !cmd[0];
         p_d.addr = adIn[31:2];
         if (hit)
         begin
            p_d.devsel_n = 1'b0;
            p_d.ctlOe = 1'b1;
            if (lockHit && !cfgCmd)
            begin
               p_d.state = pba_pkg::PBA_STOP;
               p_d.stop_n = 1'b0;
               p_d.trdy_n = 1'b1;
            end
            else
            begin
               p_d.state = pba_pkg::PBA_DATA;
               p_d.trdy_n = !cmd[0];
               p_d.lockCand = lockIn_n;
            end
         end
         else
         begin
            p_d.state = pba_pkg::PBA_BUSY;
         end
      end
      // grants move only on an idle bus; requests unseen while reset holds
      p_d.gntOe = 1'b1;
      if (frameIn_n && irdyIn_n)
      begin
         p_d.gnt_n = '1;
         if (!reqIn_n[p_q.rr])
         begin
            p_d.gnt_n[p_q.rr] = 1'b0;
            p_d.rr = !p_q.rr;
         end
         else if (!reqIn_n[!p_q.rr])
         begin
            p_d.gnt_n[!p_q.rr] = 1'b0;
         end
      end
      if (wrMem)
      begin
         p_d.wr = '{addr: p_q.addr, data: adIn, be: ~cbeIn_n};
         p_d.wrTgl = !p_q.wrTgl;
      end
   end

   always_ff @(posedge pciClk or negedge pciRst_n)
   begin
      if (!pciRst_n)
      begin
         p_q <= pba_pkg::PCI_RST;
      end
      else
      begin
         p_q <= p_d;
      end
   end

   always_ff @(posedge pciClk)
   begin
      if (wrMem)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (!cbeIn_n[b])
            begin
               mem[idx][8*b +: 8] <= adIn[8*b +: 8];
            end
         end
      end
   end

   // ***************************************************
   // system side, on mclk
   // ***************************************************
   // limitation: a write must be at least 4 mclk apart from the next,
   // which the slot clock always gives; ce held low can drop events
   always_comb
   begin
      s_d = s_q;
      s_d.tS1 = p_q.wrTgl;
      s_d.tS2 = s_q.tS1;
      s_d.tS3 = s_q.tS2;
      s_d.en = tgtEnable;
      s_d.wrStb = s_q.tS2 ^ s_q.tS3;
      if (s_q.tS2 ^ s_q.tS3)
      begin
         s_d.wr = p_q.wr;
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_q <= '0;
      end
      else if (ce)
      begin
         s_q <= s_d;
      end
   end

   assign wrAddr = s_q.wr.addr;
   assign wrData = s_q.wr.data;
   assign wrBe = s_q.wr.be;
   assign wrStrobe = s_q.wrStb;
   assign adOut = p_q.adOut;
   assign adOe = p_q.adOe;
   assign cbeOut_n = 4'h0;
   assign cbeOe = p_q.cbeOe;
   assign parOut = p_q.parOut;
   assign parOe = p_q.parOe;
   assign devselOut_n = p_q.devsel_n;
   assign trdyOut_n = p_q.trdy_n;
   assign stopOut_n = p_q.stop_n;
   assign ctlOe = p_q.ctlOe;
   assign perrOut_n = p_q.perr_n;
   assign perrOe = p_q.perrOe;
   assign serrOut_n = 1'b0;
   assign serrOe = p_q.serrOe;
   assign gntOut_n = p_q.gnt_n;
   assign gntOe = p_q.gntOe;

   // ***************************************************
   // checks
   // ***************************************************
   sequence s_badWrPar;
      xfer && !p_q.rd ##1 parIn != p_q.dParCalc;
   endsequence
   sequence s_lastXfer;
      xfer && frameIn_n;
   endsequence
   property p_perrLate;
      @(posedge pciClk) disable iff (!pciRst_n) s_badWrPar |=> perrOe && !perrOut_n;
   endproperty
   a_perrLate: assert property (p_perrLate) else $error("data parity error not flagged");
   property p_serrOne;
      @(posedge pciClk) disable iff (!pciRst_n) p_q.aParChk && parIn != p_q.aParCalc |=> serrOe ##1 !serrOe;
   endproperty
   a_serrOne: assert property (p_serrOne) else $error("system error not one clock");
   property p_parLag;
      @(posedge pciClk) disable iff (!pciRst_n) adOe && p_q.state != pba_pkg::PBA_IDLE
         |=> parOe && parOut == $past(parNow);
   endproperty
   a_parLag: assert property (p_parLag) else $error("read parity late or wrong");
   property p_readValid;
      @(posedge pciClk) disable iff (!pciRst_n) p_q.state == pba_pkg::PBA_DATA && p_q.rd && !trdyOut_n
         |-> adOe && ctlOe;
   endproperty
   a_readValid: assert property (p_readValid) else $error("read ready without data");
   property p_endTurn;
      @(posedge pciClk) disable iff (!pciRst_n) s_lastXfer
         |=> ctlOe && devselOut_n && trdyOut_n && stopOut_n && !adOe ##1 !adOe;
   endproperty
   a_endTurn: assert property (p_endTurn) else $error("bad end of transaction");
   property p_burst;
      @(posedge pciClk) disable iff (!pciRst_n) xfer && !frameIn_n && !lastWord
         |=> p_q.addr == $past(p_q.addr) + 30'h1 && !trdyOut_n;
   endproperty
   a_burst: assert property (p_burst) else $error("burst did not advance");
   property p_stopHold;
      @(posedge pciClk) disable iff (!pciRst_n) !stopOut_n && !frameIn_n |=> !stopOut_n && trdyOut_n;
   endproperty
   a_stopHold: assert property (p_stopHold) else $error("stop dropped early");
   property p_cfgSel;
      @(posedge pciClk) disable iff (!pciRst_n) canClaim && addrPh && cfgCmd && !idsel |=> devselOut_n;
   endproperty
   a_cfgSel: assert property (p_cfgSel) else $error("config claimed without select");
   property p_lockRetry;
      @(posedge pciClk) disable iff (!pciRst_n) canClaim && addrPh && hit && lockHit && !cfgCmd
         |=> !devselOut_n && !stopOut_n && trdyOut_n;
   endproperty
   a_lockRetry: assert property (p_lockRetry) else $error("locked region not retried");
endmodule
`default_nettype wire

// File: pba_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// slot-side master agent
// ************************************************
module pba_master_model (
   input wire logic pciClk,
   input wire logic [31:0] adOut,
   input wire logic adOe,
   input wire logic [3:0] cbeOut_n,
   input wire logic cbeOe,
   input wire logic parOut,
   input wire logic parOe,
   input wire logic devselOut_n,
   input wire logic trdyOut_n,
   input wire logic ctlOe,
   output logic frameIn_n,
   output logic irdyIn_n,
   output logic [31:0] adIn,
   output logic [3:0] cbeIn_n,
   output logic parIn,
   output logic lockIn_n
);
   logic [31:0] mAd, lastAd;
   logic [3:0] mCbe, lastCbe;
   logic mOe, mCbeOe, mPar, mParOe, badPar, lastPar;
   logic [31:0] wData [8];
   logic [3:0] wBe [8];
   initial
   begin
      frameIn_n = 1'b1;
      irdyIn_n = 1'b1;
      lockIn_n = 1'b1;
      {mAd, lastAd, mCbe, lastCbe} = '0;
      {mOe, mCbeOe, mPar, mParOe, badPar, lastPar} = '0;
   end
   // a released line shows the inverse of its last level, so stale data cannot pass
   always_comb
   begin
      adIn = mOe ? mAd : (adOe ? adOut : ~lastAd);
      cbeIn_n = mCbeOe ? mCbe : (cbeOe ? cbeOut_n : ~lastCbe);
      parIn = mParOe ? mPar : (parOe ? parOut : ~lastPar);
   end
   always @(posedge pciClk)
   begin
      lastAd <= adIn;
      lastCbe <= cbeIn_n;
      lastPar <= parIn;
      mPar <= ^{adIn, cbeIn_n} ^ badPar;
      mParOe <= mOe;
   end
   // ************************************************
   // one transaction; gives up after 8 clocks without ready
   // ************************************************
   task automatic cycle(input logic [3:0] cmd, input logic [31:0] addr, input int n, input logic aBad,
      input logic dBad, output logic claimed);
      int waits;
      claimed = 1'b0;
      @(posedge pciClk);
      frameIn_n <= 1'b0;
      mAd <= addr;
      mCbe <= cmd;
      mOe <= 1'b1;
      mCbeOe <= 1'b1;
      badPar <= aBad;
      @(posedge pciClk);
      for (int i = 0; i < n; i++)
      begin
         irdyIn_n <= 1'b0;
         frameIn_n <= (i == n - 1);
         mOe <= cmd[0];
         mAd <= wData[i];
         mCbe <= wBe[i];
         badPar <= dBad & cmd[0];
         waits = 0;
         do
         begin
            @(posedge pciClk);
            badPar <= 1'b0;
            waits++;
            if (devselOut_n === 1'b0 && ctlOe === 1'b1)
               claimed = 1'b1;
         end
         while (!(trdyOut_n === 1'b0 && ctlOe === 1'b1) && waits < 8);
         if (waits >= 8)
            break;
      end
      frameIn_n <= 1'b1;
      irdyIn_n <= 1'b1;
      mOe <= 1'b0;
      mCbeOe <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb_parallel_pci_bus_agent.sv
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_pci_bus_agent;
   localparam logic [31:0] BASE = 32'h8000_0000;
   localparam logic [31:0] CFG = 32'h1234_5678; // arbitrary identity value
   logic mclk, reset_n, pciClk, pciRst_n, tgtEnable, idsel, wrStrobe, frameIn_n, irdyIn_n, parIn, lockIn_n;
   logic adOe, cbeOe, parOut, parOe, devselOut_n, trdyOut_n, stopOut_n, ctlOe, perrOut_n, perrOe;
   logic serrOut_n, serrOe, gntOe, prevRd;
   logic [29:0] wrAddr;
   logic [31:0] wrData, adOut, adIn, prevAd, seed, shadow [64];
   logic [3:0] wrBe, cbeOut_n, cbeIn_n, prevCbe;
   logic [1:0] reqIn_n, gntOut_n;
   pba_pkg::pba_wr_t wrQ [$];
   logic [31:0] rdQ [$];
   int n_errors, checks, cycles, serrCnt;
   pba_agent #(.DEPTH_LOG2(6), .BASE_ADDR(BASE), .CFG_ID(CFG)) i_dut (.mclk, .reset_n, .ce(1'b1),
      .tgtEnable, .wrAddr, .wrData, .wrBe, .wrStrobe, .pciClk, .pciRst_n, .frameIn_n, .irdyIn_n, .adIn,
      .cbeIn_n, .parIn, .idsel, .lockIn_n, .reqIn_n, .adOut, .adOe, .cbeOut_n, .cbeOe, .parOut, .parOe,
      .devselOut_n, .trdyOut_n, .stopOut_n, .ctlOe, .perrOut_n, .perrOe, .serrOut_n, .serrOe, .gntOut_n,
      .gntOe);
   pba_master_model i_mst (.pciClk, .adOut, .adOe, .cbeOut_n, .cbeOe, .parOut, .parOe, .devselOut_n,
      .trdyOut_n, .ctlOe, .frameIn_n, .irdyIn_n, .adIn, .cbeIn_n, .parIn, .lockIn_n);
   always #2 mclk = ~mclk;
   initial
   begin
      pciClk = 1'b0;
      #1.3;
      forever #24 pciClk = ~pciClk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0);
   endfunction
   task automatic check(input string name, input logic [65:0] exp, input logic [65:0] got);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic results();
      $display("mismatches %0d comparisons %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ************************************************
   // watchers: notes are taken off the queues as results appear
   // ************************************************
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         results();
      end
      if (wrStrobe === 1'b1 && wrQ.size() == 0)
         check("spare write", 0, 1);
      else if (wrStrobe === 1'b1)
         check("write", wrQ.pop_front(), {wrAddr, wrData, wrBe});
   end
   always @(posedge pciClk)
   begin
      serrCnt += int'(serrOe === 1'b1);
      if (prevRd)
         check("read parity", {1'b1, ^{prevAd, prevCbe}}, {parOe, parOut});
      prevRd <= (irdyIn_n === 1'b0 && trdyOut_n === 1'b0 && adOe === 1'b1);
      prevAd <= adOut;
      prevCbe <= cbeIn_n;
      if (irdyIn_n === 1'b0 && trdyOut_n === 1'b0 && adOe === 1'b1 && rdQ.size() == 0)
         check("spare read", 0, 1);
      else if (irdyIn_n === 1'b0 && trdyOut_n === 1'b0 && adOe === 1'b1)
         check("read data", rdQ.pop_front(), adOut);
   end
   // ************************************************
   // drivers
   // ************************************************
   task automatic pciReset();
      @(posedge mclk);
      pciRst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      check("park", {3'h7, 33'h0}, {adOe, cbeOe, parOe, adOut, parOut});
      check("released", 0, {ctlOe, perrOe, serrOe, gntOe});
      @(posedge pciClk);
      @(posedge mclk);
      pciRst_n <= 1'b1;
      repeat (3) @(posedge pciClk);
      check("idle", 1, {adOe, cbeOe, parOe, gntOe});
   endtask
   task automatic bus(input logic [3:0] cmd, input logic [31:0] addr, input int n, input logic sel,
      input logic aBad, input logic dBad, input logic rndBe, input logic expClaim);
      logic claimed;
      logic [5:0] idx;
      logic [3:0] be;
      logic mem;
      mem = (cmd[3:1] != 3'h5);
      @(posedge pciClk);
      idsel <= sel;
      for (int i = 0; i < n; i++)
      begin
         seed = lfsr(seed);
         be = (rndBe && cmd[0]) ? seed[7:4] : 4'h0;
         idx = addr[7:2] + i[5:0];
         i_mst.wData[i] = seed;
         i_mst.wBe[i] = be;
         if (expClaim && mem && cmd[0])
         begin
            for (int b = 0; b < 4; b++)
               if (!be[b])
                  shadow[idx][8*b+:8] = seed[8*b+:8];
            wrQ.push_back('{addr: addr[31:2] + i[29:0], data: seed, be: ~be});
         end
         if (expClaim && !cmd[0])
            rdQ.push_back(mem ? shadow[idx] : (idx == 6'h0 ? CFG : 32'h0));
      end
      i_mst.cycle(cmd, addr, n, aBad, dBad, claimed);
      check("claimed", expClaim, claimed);
   endtask
   initial
   begin
      mclk = 1'b0;
      reset_n = 1'b0;
      // slot side starts in reset so no unknown state crosses to mclk before the first reset task
      pciRst_n = 1'b0;
      tgtEnable = 1'b1;
      idsel = 1'b0;
      reqIn_n = 2'h3;
      prevRd = 1'b0;
      seed = 32'h0001_0b5b;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      pciReset();
      bus(pba_pkg::CMD_MEM_WRI, BASE, 4, 0, 0, 0, 0, 1);
      bus(pba_pkg::CMD_MEM_WR, BASE, 4, 0, 0, 0, 1, 1);
      bus(pba_pkg::CMD_MEM_RD, BASE, 4, 0, 0, 0, 0, 1);
      bus(pba_pkg::CMD_MEM_RDM, BASE + 32'h4, 1, 0, 0, 0, 0, 1);
      bus(pba_pkg::CMD_MEM_RDL, BASE + 32'h8, 2, 0, 0, 0, 0, 1);
      @(posedge mclk);
      tgtEnable <= 1'b0;
      repeat (4) @(posedge pciClk);
      bus(pba_pkg::CMD_MEM_WR, BASE, 1, 0, 0, 0, 0, 0);
      bus(pba_pkg::CMD_CFG_RD, 32'h0, 1, 1, 0, 0, 0, 1);
      bus(pba_pkg::CMD_CFG_RD, 32'h0, 1, 0, 0, 0, 0, 0);
      @(posedge mclk);
      tgtEnable <= 1'b1;
      bus(pba_pkg::CMD_CFG_WR, 32'h0, 1, 1, 0, 1, 0, 1);
      for (int k = 1; k < 5; k++)
      begin
         @(posedge pciClk);
         check("perrOe", (k == 2 || k == 3), perrOe);
         if (k == 2 || k == 3)
            check("perrOut_n", (k == 3), perrOut_n);
      end
      bus(pba_pkg::CMD_MEM_RD, 32'h1000_0000, 1, 0, 1, 0, 0, 0);
      repeat (3) @(posedge pciClk);
      check("serr clocks", 1, serrCnt);
      for (int k = 0; k < 3; k++)
      begin
         reqIn_n <= (k == 2) ? 2'h3 : (2'h2 >> k);
         repeat (3) @(posedge pciClk);
         check("grant", {1'b1, reqIn_n}, {gntOe, gntOut_n});
      end
      pciReset();
      bus(pba_pkg::CMD_MEM_WR, BASE + 32'h10, 2, 0, 0, 0, 0, 1);
      bus(pba_pkg::CMD_MEM_RD, BASE + 32'h10, 2, 0, 0, 0, 0, 1);
      repeat (4) @(posedge pciClk);
      check("pending", 0, wrQ.size() + rdQ.size());
      results();
   end
endmodule
`default_nettype wire
